// >>> rtl/cta_config_regs.sv
`timescale 1ns/1ns
module cta_config_regs (
  input wire logic core_clk,
  input wire logic srst,
  input wire cta_pkg::cta_serial_in_t serial_in,
  output logic sdata_out,
  output logic sdata_oe,
  input wire logic horiz_phase_one,
  input wire logic horiz_phase_three,
  input wire logic reset_gate_raw,
  output logic horiz_clock_one,
  output logic horiz_clock_two,
  output logic horiz_clock_three,
  output logic horiz_clock_four,
  output logic reset_gate,
  output logic [3:0] horiz_drive_en,
  output logic reset_gate_drive_en,
  input wire logic [9:0] adc_data,
  input wire logic dout_strobe,
  output logic [9:0] adc_dout,
  output logic adc_dout_oe,
  output cta_pkg::cta_cfg_t cfg
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef enum logic [2:0] {
    CTA_SP_IDLE, CTA_SP_RW, CTA_SP_ADDR, CTA_SP_DATA, CTA_SP_DONE
  } cta_sp_state_t;

  cta_sp_state_t sp_state_reg; // Serial frame state
  cta_sp_state_t sp_state_next;
  logic sck_prev_reg; // Last sampled serial clock
  logic rw_reg; // High for a read frame
  logic [7:0] addr_reg; // Address, shifted in LSB first
  logic [5:0] data_sr_reg; // Write data, shifted in LSB first
  logic [5:0] rd_sr_reg; // Read data, shifted out LSB first
  logic [2:0] bit_cnt_reg; // Bits taken in current phase
  logic [5:0] bank_reg [0:cta_pkg::CTA_BANK_DEPTH-1]; // Timing bank
  logic [7:0] opmode_reg; // Operating mode, eight bits
  logic [5:0] ctlmode_reg; // Control mode, six bits
  cta_pkg::cta_cfg_t cfg_next;
  logic sck_rise; // Serial clock rising this cycle
  logic [7:0] addr_next; // Address including the bit now arriving
  logic [5:0] wr_word; // Write data including the bit now arriving
  logic wr_fire; // One-cycle write strobe
  logic [9:0] dout_next;
  logic clk_one_next;
  logic clk_three_next;
  logic gate_next;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when an address falls in the contiguous timing bank
  function automatic logic in_bank(input logic [7:0] a);
    return (a >= cta_pkg::CTA_SEQ2_POL_OFF) &&
           (a <= cta_pkg::CTA_DAT_SMP_OFF);
  endfunction : in_bank

  // Bank index of an address in the timing bank
  function automatic logic [5:0] bank_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - cta_pkg::CTA_SEQ2_POL_OFF;
    return d[5:0];
  endfunction : bank_idx

  // Stored value of a timing register, by address
  function automatic logic [5:0] bank_at(input logic [7:0] a);
    return bank_reg[bank_idx(a)];
  endfunction : bank_at

  // Read-back value of any address; unmapped addresses read zero
  function automatic logic [5:0] read_word(input logic [7:0] a);
    logic [5:0] r;
    r = 6'h00;
    if (a == cta_pkg::CTA_OPMODE_LO_OFF) begin
      r = opmode_reg[5:0];
    end else if (a == cta_pkg::CTA_OPMODE_HI_OFF) begin
      r = {4'h0, opmode_reg[7:6]};
    end else if (a == cta_pkg::CTA_CTLMODE_OFF) begin
      r = ctlmode_reg;
    end else if (in_bank(a)) begin
      r = bank_at(a);
    end
    return r;
  endfunction : read_word

  //////////////////////////////////////////////////////////////////////////
  // Serial port: frame is one direction bit, eight address bits, six data

  assign sck_rise = serial_in.sck & ~sck_prev_reg;
  assign addr_next = {serial_in.sdata, addr_reg[7:1]};
  assign wr_word = {serial_in.sdata, data_sr_reg[5:1]};
  // Write commits on the last data bit of a write frame
  assign wr_fire = (sp_state_reg == CTA_SP_DATA) && sck_rise && !rw_reg &&
                   (bit_cnt_reg == 3'(cta_pkg::CTA_FRAME_DATA_BITS - 1));

  // Edge detector on the sampled serial clock
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= serial_in.sck;
    end
  end

  // Frame state; raising the select aborts any frame at once
  always_comb begin
    sp_state_next = sp_state_reg;
    case (sp_state_reg)
      CTA_SP_IDLE: begin
        if (!serial_in.sload_n) begin
          sp_state_next = CTA_SP_RW;
        end
      end
      CTA_SP_RW: begin
        if (sck_rise) begin
          sp_state_next = CTA_SP_ADDR;
        end
      end
      CTA_SP_ADDR: begin
        if (sck_rise && bit_cnt_reg == 3'h7) begin
          sp_state_next = CTA_SP_DATA;
        end
      end
      CTA_SP_DATA: begin
        if (sck_rise &&
            bit_cnt_reg == 3'(cta_pkg::CTA_FRAME_DATA_BITS - 1)) begin
          sp_state_next = CTA_SP_DONE;
        end
      end
      CTA_SP_DONE: begin
        sp_state_next = CTA_SP_DONE; // Extra clocks are ignored
      end
      default: begin
        sp_state_next = CTA_SP_IDLE;
      end
    endcase
    if (serial_in.sload_n) begin
      sp_state_next = CTA_SP_IDLE;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sp_state_reg <= CTA_SP_IDLE;
    end else begin
      sp_state_reg <= sp_state_next;
    end
  end

  // Bit counter, cleared at each phase change
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bit_cnt_reg <= 3'h0;
    end else if (sp_state_next != sp_state_reg) begin
      bit_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Direction, address and write data shifters
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rw_reg <= 1'b0;
      addr_reg <= 8'h00;
      data_sr_reg <= 6'h00;
    end else if (sck_rise) begin
      if (sp_state_reg == CTA_SP_RW) begin
        rw_reg <= serial_in.sdata;
      end
      if (sp_state_reg == CTA_SP_ADDR) begin
        addr_reg <= addr_next;
      end
      if (sp_state_reg == CTA_SP_DATA) begin
        data_sr_reg <= wr_word;
      end
    end
  end

  // Read shifter: loaded as the address completes, then one bit per clock.
  // The host sees each bit on its rising edge; the shift follows it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_sr_reg <= 6'h00;
    end else if (sck_rise && sp_state_reg == CTA_SP_ADDR &&
                 bit_cnt_reg == 3'h7) begin
      rd_sr_reg <= read_word(addr_next);
    end else if (sck_rise && sp_state_reg == CTA_SP_DATA) begin
      rd_sr_reg <= {1'b0, rd_sr_reg[5:1]};
    end
  end

  // Data pin is driven only in the data phase of a read frame
  assign sdata_out = rd_sr_reg[0];
  assign sdata_oe = rw_reg && (sp_state_reg == CTA_SP_DATA);

  //////////////////////////////////////////////////////////////////////////
  // Register storage

  // Timing bank; masks keep unused upper bits at zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < cta_pkg::CTA_BANK_DEPTH; i++) begin
        bank_reg[i] <= cta_pkg::CTA_BANK_RESET[i];
      end
    end else if (wr_fire && in_bank(addr_reg)) begin
      bank_reg[bank_idx(addr_reg)] <=
        wr_word & cta_pkg::CTA_BANK_MASK[bank_idx(addr_reg)];
    end
  end

  // Operating mode, written in two halves at two addresses
  always_ff @(posedge core_clk) begin
    if (srst) begin
      opmode_reg <= cta_pkg::CTA_OPMODE_RESET;
    end else if (wr_fire && addr_reg == cta_pkg::CTA_OPMODE_LO_OFF) begin
      opmode_reg[5:0] <= wr_word;
    end else if (wr_fire && addr_reg == cta_pkg::CTA_OPMODE_HI_OFF) begin
      opmode_reg[7:6] <= wr_word[1:0];
    end
  end

  // Control mode; all six bits are stored as written: colour steering,
  // gain enable, output latch and tristate
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctlmode_reg <= cta_pkg::CTA_CTLMODE_RESET;
    end else if (wr_fire && addr_reg == cta_pkg::CTA_CTLMODE_OFF) begin
      ctlmode_reg <= wr_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration decode

  always_comb begin
    cfg_next = '0;
    cfg_next.blank_start_pol = {1'(bank_at(cta_pkg::CTA_SEQ3_POL_OFF)),
      1'(bank_at(cta_pkg::CTA_SEQ2_POL_OFF))};
    cfg_next.blank_first_toggle[0] = {
      bank_at(cta_pkg::CTA_SEQ2_TOG1_HI_OFF),
      bank_at(cta_pkg::CTA_SEQ2_TOG1_LO_OFF)};
    cfg_next.blank_second_toggle[0] = {
      bank_at(cta_pkg::CTA_SEQ2_TOG2_HI_OFF),
      bank_at(cta_pkg::CTA_SEQ2_TOG2_LO_OFF)};
    cfg_next.blank_first_toggle[1] = {
      bank_at(cta_pkg::CTA_SEQ3_TOG1_HI_OFF),
      bank_at(cta_pkg::CTA_SEQ3_TOG1_LO_OFF)};
    cfg_next.blank_second_toggle[1] = {
      bank_at(cta_pkg::CTA_SEQ3_TOG2_HI_OFF),
      bank_at(cta_pkg::CTA_SEQ3_TOG2_LO_OFF)};
    // Position zero has no storage and is always pixel zero
    cfg_next.sequence_change_position[0] = 12'h000;
    cfg_next.sequence_change_position[1] = {
      bank_at(cta_pkg::CTA_CHG1_POS_HI_OFF),
      bank_at(cta_pkg::CTA_CHG1_POS_LO_OFF)};
    cfg_next.sequence_change_position[2] = {
      bank_at(cta_pkg::CTA_CHG2_POS_HI_OFF),
      bank_at(cta_pkg::CTA_CHG2_POS_LO_OFF)};
    cfg_next.sequence_change_position[3] = {
      bank_at(cta_pkg::CTA_CHG3_POS_HI_OFF),
      bank_at(cta_pkg::CTA_CHG3_POS_LO_OFF)};
    cfg_next.sequence_pointer[0] =
      2'(bank_at(cta_pkg::CTA_CHG0_PTR_OFF));
    cfg_next.sequence_pointer[1] =
      2'(bank_at(cta_pkg::CTA_CHG1_PTR_OFF));
    cfg_next.sequence_pointer[2] =
      2'(bank_at(cta_pkg::CTA_CHG2_PTR_OFF));
    cfg_next.sequence_pointer[3] =
      2'(bank_at(cta_pkg::CTA_CHG3_PTR_OFF));
    cfg_next.horiz_clk1_polarity = 1'(bank_at(cta_pkg::CTA_HC1_POL_OFF));
    cfg_next.horiz_clk1_rise_edge =
      cta_pkg::cta_edge_decode(bank_at(cta_pkg::CTA_HC1_RISE_OFF));
    cfg_next.horiz_clk1_fall_edge =
      cta_pkg::cta_edge_decode(bank_at(cta_pkg::CTA_HC1_FALL_OFF));
    cfg_next.horiz_drive_code[0] =
      3'(bank_at(cta_pkg::CTA_HC1_DRV_OFF));
    cfg_next.horiz_drive_code[1] =
      3'(bank_at(cta_pkg::CTA_HC2_DRV_OFF));
    cfg_next.horiz_drive_code[2] =
      3'(bank_at(cta_pkg::CTA_HC3_DRV_OFF));
    cfg_next.horiz_drive_code[3] =
      3'(bank_at(cta_pkg::CTA_HC4_DRV_OFF));
    cfg_next.reset_gate_polarity = 1'(bank_at(cta_pkg::CTA_GATE_POL_OFF));
    cfg_next.reset_gate_rise_edge =
      cta_pkg::cta_edge_decode(bank_at(cta_pkg::CTA_GATE_RISE_OFF));
    cfg_next.reset_gate_fall_edge =
      cta_pkg::cta_edge_decode(bank_at(cta_pkg::CTA_GATE_FALL_OFF));
    cfg_next.reset_gate_drive_code =
      3'(bank_at(cta_pkg::CTA_GATE_DRV_OFF));
    cfg_next.reference_sample_edge =
      cta_pkg::cta_edge_decode(bank_at(cta_pkg::CTA_REF_SMP_OFF));
    cfg_next.data_sample_edge =
      cta_pkg::cta_edge_decode(bank_at(cta_pkg::CTA_DAT_SMP_OFF));
    cfg_next.power_state = cta_pkg::cta_power_t'(
      opmode_reg[cta_pkg::CTA_OP_PWR_LSB +: 2]);
    cfg_next.clamp_disable =
      opmode_reg[cta_pkg::CTA_OP_CLAMP_DIS_BIT];
    cfg_next.test_bits = opmode_reg[7:3];
    cfg_next.colour_steer = cta_pkg::cta_steer_t'(
      ctlmode_reg[cta_pkg::CTA_CTL_STEER_LSB +: 3]);
    cfg_next.gain_amp_enable =
      ctlmode_reg[cta_pkg::CTA_CTL_GAIN_EN_BIT];
  end

  // Configuration is registered so the timing core sees clean levels
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg <= '0;
    end else begin
      cfg <= cfg_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock outputs: polarity applied here, partners are exact inverses

  assign clk_one_next = horiz_phase_one ^ cfg.horiz_clk1_polarity;
  assign clk_three_next = horiz_phase_three;
  assign gate_next = reset_gate_raw ^ cfg.reset_gate_polarity;

  // One flop per clock; the inverse is taken after the flop so the pair
  // can never be skewed by a cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      horiz_clock_one <= 1'b0;
      horiz_clock_three <= 1'b0;
      reset_gate <= 1'b0;
    end else begin
      horiz_clock_one <= clk_one_next;
      horiz_clock_three <= clk_three_next;
      reset_gate <= gate_next;
    end
  end

  assign horiz_clock_two = ~horiz_clock_one;
  assign horiz_clock_four = ~horiz_clock_three;

  // Drive code zero switches a driver off; other codes only set current
  for (genvar k = 0; k < 4; k++) begin : g_drive
    assign horiz_drive_en[k] = |cfg.horiz_drive_code[k];
  end
  assign reset_gate_drive_en = |cfg.reset_gate_drive_code;

  //////////////////////////////////////////////////////////////////////////
  // Converter output latch and output enable

  // Transparent mode follows every cycle; latched mode waits for strobe
  always_comb begin
    dout_next = adc_dout;
    if (ctlmode_reg[cta_pkg::CTA_CTL_LATCH_BIT] || dout_strobe) begin
      dout_next = adc_data;
    end
  end

  // Output data register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      adc_dout <= 10'h000;
    end else begin
      adc_dout <= dout_next;
    end
  end

  // Outputs driven while the tristate bit is low
  assign adc_dout_oe = ~ctlmode_reg[cta_pkg::CTA_CTL_TRISTATE_BIT];

endmodule : cta_config_regs

// >>> rtl/cta_pkg.sv
// Function
// - Change position zero is fixed at pixel zero
// - Each change position has a two-bit sequence pointer
// - Toggle positions are twelve bits, two six-bit halves
// - Each blanking sequence has a start polarity bit
// - First horizontal pair polarity: zero plain, one inverted
// - First horizontal clock edges from two six-bit fields
// - Four horizontal drive codes, zero off, 3.5 mA steps
// - Reset gate polarity: zero plain, one inverted
// - Reset gate edges from two six-bit fields
// - Reset gate drive code, zero off, 3.5 mA steps
// - Reference and data sample locations, six bits each
// - Operating mode split over serial addresses 0x00, 0x01
// - Power field selects four power states
// - Operating mode bit two disables black clamp
// - Control mode at address 0x06, resets to zero
// - Three-bit colour steering selects eight modes
// - Control mode bit three enables pixel gain stage
// - Output latch bit: zero latched, one transparent
// - Control mode bit five tristates converter outputs
// - Edge codes map to 48 edges, four quadrants
// - Second and fourth clocks invert first and third
package cta_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Serial addresses

  localparam logic [7:0] CTA_OPMODE_LO_OFF = 8'h00; // Operating mode [5:0]
  localparam logic [7:0] CTA_OPMODE_HI_OFF = 8'h01; // Operating mode [7:6]
  localparam logic [7:0] CTA_CTLMODE_OFF = 8'h06; // Control mode [5:0]
  localparam logic [7:0] CTA_SEQ2_POL_OFF = 8'hd1;
  localparam logic [7:0] CTA_SEQ2_TOG1_LO_OFF = 8'hd2;
  localparam logic [7:0] CTA_SEQ2_TOG1_HI_OFF = 8'hd3;
  localparam logic [7:0] CTA_SEQ2_TOG2_LO_OFF = 8'hd4;
  localparam logic [7:0] CTA_SEQ2_TOG2_HI_OFF = 8'hd5;
  localparam logic [7:0] CTA_SEQ3_POL_OFF = 8'hd6;
  localparam logic [7:0] CTA_SEQ3_TOG1_LO_OFF = 8'hd7;
  localparam logic [7:0] CTA_SEQ3_TOG1_HI_OFF = 8'hd8;
  localparam logic [7:0] CTA_SEQ3_TOG2_LO_OFF = 8'hd9;
  localparam logic [7:0] CTA_SEQ3_TOG2_HI_OFF = 8'hda;
  localparam logic [7:0] CTA_CHG0_PTR_OFF = 8'hdb;
  localparam logic [7:0] CTA_CHG1_POS_LO_OFF = 8'hdc;
  localparam logic [7:0] CTA_CHG1_POS_HI_OFF = 8'hdd;
  localparam logic [7:0] CTA_CHG1_PTR_OFF = 8'hde;
  localparam logic [7:0] CTA_CHG2_POS_LO_OFF = 8'hdf;
  localparam logic [7:0] CTA_CHG2_POS_HI_OFF = 8'he0;
  localparam logic [7:0] CTA_CHG2_PTR_OFF = 8'he1;
  localparam logic [7:0] CTA_CHG3_POS_LO_OFF = 8'he2;
  localparam logic [7:0] CTA_CHG3_POS_HI_OFF = 8'he3;
  localparam logic [7:0] CTA_CHG3_PTR_OFF = 8'he4;
  localparam logic [7:0] CTA_HC1_POL_OFF = 8'he5;
  localparam logic [7:0] CTA_HC1_RISE_OFF = 8'he6;
  localparam logic [7:0] CTA_HC1_FALL_OFF = 8'he7;
  localparam logic [7:0] CTA_HC1_DRV_OFF = 8'he8;
  localparam logic [7:0] CTA_HC2_DRV_OFF = 8'he9;
  localparam logic [7:0] CTA_HC3_DRV_OFF = 8'hea;
  localparam logic [7:0] CTA_HC4_DRV_OFF = 8'heb;
  localparam logic [7:0] CTA_GATE_POL_OFF = 8'hec;
  localparam logic [7:0] CTA_GATE_RISE_OFF = 8'hed;
  localparam logic [7:0] CTA_GATE_FALL_OFF = 8'hee;
  localparam logic [7:0] CTA_GATE_DRV_OFF = 8'hef;
  localparam logic [7:0] CTA_REF_SMP_OFF = 8'hf0;
  localparam logic [7:0] CTA_DAT_SMP_OFF = 8'hf1;

  // Contiguous timing bank spans the first to the last timing address
  localparam int CTA_BANK_DEPTH = 33;

  //////////////////////////////////////////////////////////////////////////
  // Reset values and writable masks of the timing bank, by bank index

  localparam logic [5:0] CTA_BANK_RESET [0:CTA_BANK_DEPTH-1] = '{
    6'h00, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h01, 6'h3f, 6'h3f, 6'h3f,
    6'h3f, 6'h02, 6'h01, 6'h00, 6'h01, 6'h02, 6'h00, 6'h00, 6'h37,
    6'h03, 6'h02, 6'h00, 6'h00, 6'h20, 6'h03, 6'h03, 6'h03, 6'h03,
    6'h00, 6'h00, 6'h10, 6'h02, 6'h24, 6'h00};
  localparam logic [5:0] CTA_BANK_MASK [0:CTA_BANK_DEPTH-1] = '{
    6'h01, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h01, 6'h3f, 6'h3f, 6'h3f,
    6'h3f, 6'h03, 6'h3f, 6'h3f, 6'h03, 6'h3f, 6'h3f, 6'h03, 6'h3f,
    6'h3f, 6'h03, 6'h01, 6'h3f, 6'h3f, 6'h07, 6'h07, 6'h07, 6'h07,
    6'h01, 6'h3f, 6'h3f, 6'h07, 6'h3f, 6'h3f};

  localparam logic [7:0] CTA_OPMODE_RESET = 8'h00; // Operating mode reset
  localparam logic [5:0] CTA_CTLMODE_RESET = 6'h00; // Control mode reset

  //////////////////////////////////////////////////////////////////////////
  // Field positions

  localparam int CTA_OP_PWR_LSB = 0; // Power state [1:0]
  localparam int CTA_OP_CLAMP_DIS_BIT = 2; // Black clamp disable
  localparam int CTA_CTL_STEER_LSB = 0; // Colour steering [2:0]
  localparam int CTA_CTL_GAIN_EN_BIT = 3; // Pixel gain enable
  localparam int CTA_CTL_LATCH_BIT = 4; // Output latch transparent
  localparam int CTA_CTL_TRISTATE_BIT = 5; // Converter outputs off
  localparam logic [3:0] CTA_QUAD_SIZE = 4'hc; // Edges per quadrant
  localparam int CTA_FRAME_DATA_BITS = 6; // Data bits per frame

  //////////////////////////////////////////////////////////////////////////
  // Enumerations and carriers

  typedef enum logic [1:0] {
    CTA_PWR_FULL, CTA_PWR_FAST_RECOVERY, CTA_PWR_REF_STANDBY,
    CTA_PWR_SHUTDOWN
  } cta_power_t;

  typedef enum logic [2:0] {
    CTA_STEER_OFF, CTA_STEER_MOSAIC_SEP, CTA_STEER_MOSAIC_INTERLACED,
    CTA_STEER_MOSAIC_REPEAT, CTA_STEER_THREE, CTA_STEER_THREE_II,
    CTA_STEER_FOUR, CTA_STEER_FOUR_II
  } cta_steer_t;

  // Serial port pins as seen by the block
  typedef struct packed {
    logic sck; // Serial clock, sampled
    logic sdata; // Serial data from host
    logic sload_n; // Frame select, low active
  } cta_serial_in_t;

  // Decoded edge location: index, 0 to 47 when valid, and a validity flag
  typedef struct packed {
    logic valid;
    logic [5:0] index;
  } cta_edge_t;

  // Configuration handed to the timing core and analog front end
  typedef struct packed {
    logic [1:0] blank_start_pol; // [0] sequence 2, [1] sequence 3
    logic [1:0][11:0] blank_first_toggle;
    logic [1:0][11:0] blank_second_toggle;
    logic [3:0][11:0] sequence_change_position;
    logic [3:0][1:0] sequence_pointer;
    logic horiz_clk1_polarity;
    cta_edge_t horiz_clk1_rise_edge;
    cta_edge_t horiz_clk1_fall_edge;
    logic [3:0][2:0] horiz_drive_code;
    logic reset_gate_polarity;
    cta_edge_t reset_gate_rise_edge;
    cta_edge_t reset_gate_fall_edge;
    logic [2:0] reset_gate_drive_code;
    cta_edge_t reference_sample_edge;
    cta_edge_t data_sample_edge;
    cta_power_t power_state;
    logic clamp_disable;
    logic [4:0] test_bits; // Operating mode [7:3]
    cta_steer_t colour_steer;
    logic gain_amp_enable;
  } cta_cfg_t;

  //////////////////////////////////////////////////////////////////////////
  // Edge code decode, used for every edge field

  function automatic cta_edge_t cta_edge_decode(input logic [5:0] code);
    cta_edge_t e;
    logic [5:0] base;
    base = {code[5:4], 4'h0} - {2'h0, code[5:4], 2'h0};
    e.valid = (code[3:0] < CTA_QUAD_SIZE);
    e.index = base + {2'h0, code[3:0]};
    return e;
  endfunction : cta_edge_decode

endpackage : cta_pkg

// >>> tb/cta_config_regs_asserts.sv
`timescale 1ns/1ns
module cta_config_regs_asserts (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic horiz_phase_one,
  input wire logic reset_gate_raw,
  input wire logic horiz_clock_one,
  input wire logic horiz_clock_two,
  input wire logic horiz_clock_three,
  input wire logic horiz_clock_four,
  input wire logic reset_gate,
  input wire logic [3:0] horiz_drive_en,
  input wire logic reset_gate_drive_en,
  input wire cta_pkg::cta_cfg_t cfg
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_CHG0_FIXED: assert property (
    cfg.sequence_change_position[0] == 12'h000)
    else $error("change position zero moved off pixel zero");
  AST_CLK2_INVERSE: assert property (
    horiz_clock_two == !horiz_clock_one)
    else $error("second horizontal clock is not the inverse");
  AST_CLK4_INVERSE: assert property (
    horiz_clock_four == !horiz_clock_three)
    else $error("fourth horizontal clock is not the inverse");
  // Polarity is only judged while it is steady, since reg and cfg differ
  AST_CLK1_POLARITY: assert property (
    !$past(srst) && $stable(cfg.horiz_clk1_polarity) |->
    horiz_clock_one == ($past(horiz_phase_one) ^ cfg.horiz_clk1_polarity))
    else $error("first horizontal clock polarity wrong");
  AST_GATE_POLARITY: assert property (
    !$past(srst) && $stable(cfg.reset_gate_polarity) |->
    reset_gate == ($past(reset_gate_raw) ^ cfg.reset_gate_polarity))
    else $error("reset gate polarity wrong");
  AST_HDRV_OFF: assert property (
    horiz_drive_en == {|cfg.horiz_drive_code[3], |cfg.horiz_drive_code[2],
    |cfg.horiz_drive_code[1], |cfg.horiz_drive_code[0]})
    else $error("horizontal drive enable disagrees with code");
  AST_GATE_DRV_OFF: assert property (
    reset_gate_drive_en == |cfg.reset_gate_drive_code)
    else $error("reset gate drive enable disagrees with code");
  AST_EDGE_RANGE: assert property (
    cfg.horiz_clk1_rise_edge.valid |-> cfg.horiz_clk1_rise_edge.index < 6'h30)
    else $error("valid edge index beyond 47");
  cover property (horiz_clock_one && cfg.horiz_clk1_polarity);
  cover property (reset_gate && cfg.reset_gate_polarity);
  cover property (horiz_drive_en == 4'he);
endmodule : cta_config_regs_asserts
bind cta_config_regs cta_config_regs_asserts u_chk (.core_clk, .srst, .cfg,
  .horiz_phase_one, .reset_gate_raw, .horiz_clock_one, .horiz_clock_two,
  .horiz_clock_three, .horiz_clock_four, .reset_gate, .horiz_drive_en,
  .reset_gate_drive_en);

// >>> tb/cta_host_model.sv
`timescale 1ns/1ns
module cta_host_model (
  input wire logic core_clk,
  input wire logic sdata_out,
  input wire logic sdata_oe,
  output cta_pkg::cta_serial_in_t serial_in
);
  logic sck, drv, sel_n;
  // Shared data pin: the device wins while it drives, else the host bit
  assign serial_in = {sck, sdata_oe ? sdata_out : drv, sel_n};
  initial begin
    sck = 1'b0;
    drv = 1'b0;
    sel_n = 1'b1;
  end
  // One frame: direction, address and data LSB first, two cycles per level
  task automatic xfer(input logic rw, input logic [7:0] a,
    input logic [5:0] d, output logic [5:0] q);
    logic [14:0] b;
    b = {d, a, rw};
    q = 6'h00;
    @(negedge core_clk) sel_n = 1'b0;
    for (int i = 0; i < 15; i++) begin
      @(negedge core_clk) sck = 1'b0;
      // Released pin toggles so a missing driver never reads as valid
      drv = (rw && i > 8) ? ~drv : b[i];
      repeat (2) @(negedge core_clk);
      if (i > 8) q[i-9] = serial_in.sdata;
      sck = 1'b1;
      @(negedge core_clk);
    end
    @(negedge core_clk) sck = 1'b0;
    sel_n = 1'b1;
    @(negedge core_clk);
  endtask : xfer
endmodule : cta_host_model

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic core_clk, srst, horiz_phase_one, horiz_phase_three, reset_gate_raw;
  logic sdata_out, sdata_oe, horiz_clock_one, horiz_clock_two, dout_strobe;
  logic horiz_clock_three, horiz_clock_four, reset_gate, reset_gate_drive_en;
  logic adc_dout_oe;
  logic [3:0] horiz_drive_en;
  logic [9:0] adc_data, adc_dout;
  logic [5:0] q;
  cta_pkg::cta_serial_in_t serial_in;
  cta_pkg::cta_cfg_t cfg;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  // Field width per address from 0xd1 upward, and reset values
  localparam string WID = "166661666626626626621663333166366";
  localparam logic [5:0] RST [33] = '{6'h00, 6'h3f, 6'h3f, 6'h3f, 6'h3f,
    6'h01, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h02, 6'h01, 6'h00, 6'h01, 6'h02,
    6'h00, 6'h00, 6'h37, 6'h03, 6'h02, 6'h00, 6'h00, 6'h20, 6'h03, 6'h03,
    6'h03, 6'h03, 6'h00, 6'h00, 6'h10, 6'h02, 6'h24, 6'h00};
  cta_config_regs dut (.core_clk, .srst, .serial_in, .sdata_out, .sdata_oe,
    .horiz_phase_one, .horiz_phase_three, .reset_gate_raw, .horiz_clock_one,
    .horiz_clock_two, .horiz_clock_three, .horiz_clock_four, .reset_gate,
    .horiz_drive_en, .reset_gate_drive_en, .adc_data, .dout_strobe, .adc_dout,
    .adc_dout_oe, .cfg);
  cta_host_model host (.core_clk, .sdata_out, .sdata_oe, .serial_in);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // A hang counts as a mismatch
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [11:0] g,
    input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [5:0] d);
    host.xfer(1'b0, a, d, q);
    repeat (2) @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [5:0] e, input string n);
    host.xfer(1'b1, a, 6'h00, q);
    chk(n, {6'h00, q}, {6'h00, e});
  endtask : rd
  initial begin
    srst = 1'b1;
    {horiz_phase_one, horiz_phase_three, reset_gate_raw, dout_strobe} = 4'h0;
    adc_data = 10'h000;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    rd(8'h00, 6'h00, "opmode reset");
    rd(8'h06, 6'h00, "ctlmode reset");
    rd(8'h50, 6'h00, "unmapped");
    for (int i = 0; i < 33; i++) begin
      rd(8'hd1 + 8'(i), RST[i], "bank reset");
    end
    // All ones in, only the field's own bits come back
    for (int i = 0; i < 33; i++) begin
      wr(8'hd1 + 8'(i), 6'h3f);
      rd(8'hd1 + 8'(i), 6'(7'h7f >> (8'h37 - WID[i])), "bank mask");
    end
    chk("start pol", 12'(cfg.blank_start_pol), 12'h003);
    chk("pointer", 12'(cfg.sequence_pointer[3]), 12'h003);
    wr(8'hd2, 6'h05);
    chk("toggle", cfg.blank_first_toggle[0], 12'hfc5);
    wr(8'he6, 6'h1b);
    chk("edge q2", 12'(cfg.horiz_clk1_rise_edge), 12'h057);
    wr(8'he6, 6'h0c);
    chk("edge bad", 12'(cfg.horiz_clk1_rise_edge), 12'h00c);
    {horiz_phase_one, horiz_phase_three, reset_gate_raw} = 3'h7;
    repeat (2) @(negedge core_clk);
    chk("clocks inv",
      12'({horiz_clock_one, reset_gate, horiz_clock_four}), 12'h0);
    wr(8'he5, 6'h00);
    wr(8'hec, 6'h00);
    chk("clocks",
      12'({horiz_clock_one, reset_gate, horiz_clock_three}), 12'h7);
    wr(8'he8, 6'h00);
    chk("h drive", 12'(horiz_drive_en), 12'h00e);
    wr(8'hef, 6'h00);
    chk("gate drive", 12'(reset_gate_drive_en), 12'h000);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 6'h14 | 6'(p));
      chk("power", {9'h000, cfg.clamp_disable, cfg.power_state},
        12'(4 + p));
    end
    wr(8'h01, 6'h00);
    rd(8'h00, 6'h17, "opmode low");
    chk("test bits", 12'(cfg.test_bits), 12'h002);
    for (int s = 0; s < 8; s++) begin
      wr(8'h06, {2'b00, s[0], s[2:0]});
      chk("steer", {8'h00, cfg.gain_amp_enable, cfg.colour_steer},
        12'(s + 8 * (s % 2)));
    end
    wr(8'h06, 6'h10);
    adc_data = 10'h2a5;
    repeat (2) @(negedge core_clk);
    chk("transparent", 12'(adc_dout), 12'h2a5);
    wr(8'h06, 6'h00);
    adc_data = 10'h15a;
    repeat (2) @(negedge core_clk);
    chk("latched", 12'(adc_dout), 12'h2a5);
    dout_strobe = 1'b1;
    @(negedge core_clk) dout_strobe = 1'b0;
    @(negedge core_clk);
    chk("strobed", 12'(adc_dout), 12'h15a);
    chk("driven", 12'(adc_dout_oe), 12'h001);
    wr(8'h06, 6'h20);
    chk("tristate", 12'(adc_dout_oe), 12'h000);
    give_verdict();
  end
endmodule : tb
